// *** verilog/gpe_pkg.sv ***
package gpe_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_PORTS = 3;
  localparam int PORT_W    = 8;
  localparam int NUM_PINS  = 21;
  localparam int PORT_TWO_W = 5;
  localparam logic [7:0] FULL_MASK     = 8'hFF;
  localparam logic [7:0] PORT_TWO_MASK = 8'h1F;
  localparam int HI_DRIVE_A = 8;
  localparam int HI_DRIVE_B = 9;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // Register byte offsets; each group of three is one word per port
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_DATA0   = 8'h00;
  localparam logic [7:0] OFF_FSEL0   = 8'h0C;
  localparam logic [7:0] OFF_DIR0    = 8'h18;
  localparam logic [7:0] OFF_INP0    = 8'h24;
  localparam logic [7:0] OFF_FLAG0   = 8'h30;
  localparam logic [7:0] OFF_P1EN    = 8'h3C;
  localparam logic [7:0] OFF_PIN_IRQ_CONTROL   = 8'h40;
  localparam logic [7:0] OFF_IENA    = 8'h44;
  localparam logic [7:0] OFF_IENB    = 8'h48;
  localparam logic [7:0] OFF_MODIFY  = 8'h4C;
  localparam logic [7:0] PORT_STRIDE = 8'h04;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PIN_IRQ_CONTROL_EDGE0 = 0;
  localparam int PIN_IRQ_CONTROL_P0_LO = 3;
  localparam int PIN_IRQ_CONTROL_P0_HI = 4;
  localparam int PIN_IRQ_CONTROL_P2_EN = 5;
  localparam int PIN_IRQ_CONTROL_W     = 6;
  localparam int IENA_P0     = 0;
  localparam int IENB_P1     = 1;
  localparam int IENB_P2     = 2;
  localparam int INP2_PD_LSB = 5;
  localparam int MOD_PORT_LSB = 0;
  localparam int MOD_OP_LSB   = 4;
  localparam int MOD_BIT_LSB  = 8;
  localparam int MOD_VAL_LSB  = 16;

  // Latch modify operations
  localparam logic [2:0] MOD_AND  = 3'h0;
  localparam logic [2:0] MOD_OR   = 3'h1;
  localparam logic [2:0] MOD_XOR  = 3'h2;
  localparam logic [2:0] MOD_BCLR = 3'h3;
  localparam logic [2:0] MOD_BSET = 3'h4;
  localparam logic [2:0] MOD_BCPL = 3'h5;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] fsel;
    logic [7:0] dir;
    logic [7:0] inp;
  } gpe_port_cfg_t;

  typedef struct packed {
    logic [NUM_PINS-1:0] out;
    logic [NUM_PINS-1:0] oe;
    logic [NUM_PINS-1:0] pull_up;
    logic [NUM_PINS-1:0] pull_down;
  } gpe_pins_t;

endpackage

// *** verilog/gpe_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module gpe_sync #(
  parameter int W = 21
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  // ----------------------------------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } gpe_sync_state_t;

  gpe_sync_state_t state_reg;
  gpe_sync_state_t state_next;

  // First stage feeds only the second
  always_comb
  begin
    state_next        = state_reg;
    state_next.stage1 = async_in;
    state_next.stage2 = state_reg.stage1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign sync_out = state_reg.stage2;

endmodule
`default_nettype wire

// *** verilog/gpe_edge.sv ***
`timescale 1ns/10ps
`default_nettype none
module gpe_edge #(
  parameter int W = 21
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] level,
  input  wire logic [W-1:0] falling,
  input  wire logic [W-1:0] qualify,
  output logic      [W-1:0] edge_hit,
  output logic      [W-1:0] toggle_hit
);

  // ----------------------------------------------------------------
  // Per-pin edge detector
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] prev;
    logic [3:0]   warm;
  } gpe_edge_state_t;

  gpe_edge_state_t state_reg;
  gpe_edge_state_t state_next;

  // Warm-up hides edges from synchroniser fill and pulls waking after reset
  always_comb
  begin
    state_next      = state_reg;
    state_next.prev = level;
    state_next.warm = {state_reg.warm[2:0], 1'b1};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  // Any change, gated to general-purpose inputs
  assign toggle_hit = state_reg.warm[3] ? ((level ^ state_reg.prev) & qualify) : '0;
  // Rising when select low, falling when high
  assign edge_hit   = toggle_hit & (level ^ falling);

endmodule
`default_nettype wire

// *** verilog/gpe_top.sv ***
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module gpe_top (
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [7:0]                      paddr,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire logic [gpe_pkg::NUM_PINS-1:0]    pin_in,
  input  wire logic [gpe_pkg::NUM_PINS-1:0]    periph_out,
  input  wire logic [gpe_pkg::NUM_PINS-1:0]    periph_oe,
  input  wire logic                            deep_sleep_mode_a,
  input  wire logic                            deep_sleep_mode_b,
  output var gpe_pkg::gpe_pins_t               pins,
  output logic                                 irq_port_zero,
  output logic                                 irq_port_one,
  output logic                                 irq_port_two,
  output logic                                 port_zero_dma_trigger,
  output logic                                 port_one_dma_trigger
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0][7:0]                  latch;
    gpe_pkg::gpe_port_cfg_t [2:0]     cfg;
    logic [2:0][7:0]                  flags;
    logic [7:0]                       port_one_pin_enables;
    logic [gpe_pkg::PIN_IRQ_CONTROL_W-1:0]      pin_irq_control;
    logic                             port_zero_irq_enable;
    logic                             port_one_irq_enable;
    logic                             port_two_irq_enable;
    gpe_pkg::gpe_pins_t               pins;
    logic [2:0]                       irq;
    logic [1:0]                       dma;
    logic [31:0]                      prdata;
    logic                             pready;
    logic                             pslverr;
  } gpe_state_t;

  gpe_state_t                  state_reg;
  gpe_state_t                  state_next;
  logic [gpe_pkg::NUM_PINS-1:0] pin_level;
  logic [gpe_pkg::NUM_PINS-1:0] edge_hit;
  logic [gpe_pkg::NUM_PINS-1:0] toggle_hit;
  logic [gpe_pkg::NUM_PINS-1:0] gpio_input;
  logic [gpe_pkg::NUM_PINS-1:0] falling_sel;
  logic [gpe_pkg::NUM_PINS-1:0] fsel_flat;
  logic [gpe_pkg::NUM_PINS-1:0] dir_flat;
  logic [gpe_pkg::NUM_PINS-1:0] inp_flat;
  logic [gpe_pkg::NUM_PINS-1:0] latch_flat;
  logic [gpe_pkg::NUM_PINS-1:0] pd_flat;
  logic [2:0][7:0]              pin_bytes;
  logic [2:0][7:0]              hit_bytes;
  logic [2:0][7:0]              toggle_bytes;
  logic [2:0][7:0]              pin_en_bytes;
  logic [31:0]                  rdata;
  logic                         wr_done;
  logic                         deep_sleep;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Port two keeps only five bits
  function automatic logic [7:0] port_mask(input int p);
    port_mask = (p == 2) ? gpe_pkg::PORT_TWO_MASK : gpe_pkg::FULL_MASK;
  endfunction

  // Three port bytes to the 21-pin vector
  function automatic logic [gpe_pkg::NUM_PINS-1:0] flat21(input logic [2:0][7:0] b);
    flat21 = {b[2][gpe_pkg::PORT_TWO_W-1:0], b[1], b[0]};
  endfunction

  // 21-pin vector back to port bytes
  function automatic logic [2:0][7:0] bytes21(input logic [gpe_pkg::NUM_PINS-1:0] v);
    bytes21 = {{3'h0, v[20:16]}, v[15:8], v[7:0]};
  endfunction

  // Word-aligned and inside the map
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a[1:0] == 2'h0) && (a <= gpe_pkg::OFF_MODIFY);
  endfunction

  // Offset of the given port within a group
  function automatic logic [7:0] port_off(input logic [7:0] base, input int p);
    port_off = base + 8'(p * 4);
  endfunction

  // Latch update for byte and single-bit operations
  function automatic logic [7:0] modify_latch(input logic [7:0] old, input logic [2:0] op,
                                              input logic [2:0] bit_idx, input logic [7:0] val);
    logic [7:0] one_hot;
    one_hot = 8'h01 << bit_idx;
    case (op)
      gpe_pkg::MOD_AND:  modify_latch = old & val;
      gpe_pkg::MOD_OR:   modify_latch = old | val;
      gpe_pkg::MOD_XOR:  modify_latch = old ^ val;
      gpe_pkg::MOD_BCLR: modify_latch = old & ~one_hot;
      gpe_pkg::MOD_BSET: modify_latch = old | one_hot;
      gpe_pkg::MOD_BCPL: modify_latch = old ^ one_hot;
      default:           modify_latch = old;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Pin sampling and edge detection
  // ----------------------------------------------------------------
  gpe_sync #(
    .W (gpe_pkg::NUM_PINS)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (pin_in),
    .sync_out (pin_level)
  );

  gpe_edge #(
    .W (gpe_pkg::NUM_PINS)
  ) u_edge (
    .pclk       (pclk),
    .presetn    (presetn),
    .level      (pin_level),
    .falling    (falling_sel),
    .qualify    (gpio_input),
    .edge_hit   (edge_hit),
    .toggle_hit (toggle_hit)
  );

  // Flattened configuration views
  always_comb
  begin
    fsel_flat  = flat21({state_reg.cfg[2].fsel, state_reg.cfg[1].fsel, state_reg.cfg[0].fsel});
    dir_flat   = flat21({state_reg.cfg[2].dir, state_reg.cfg[1].dir, state_reg.cfg[0].dir});
    inp_flat   = flat21({state_reg.cfg[2].inp, state_reg.cfg[1].inp, state_reg.cfg[0].inp});
    latch_flat = flat21(state_reg.latch);
    pd_flat    = {{5{state_reg.cfg[2].inp[gpe_pkg::INP2_PD_LSB+2]}},
                  {8{state_reg.cfg[2].inp[gpe_pkg::INP2_PD_LSB+1]}},
                  {8{state_reg.cfg[2].inp[gpe_pkg::INP2_PD_LSB]}}};
    gpio_input = ~fsel_flat & ~dir_flat;
    falling_sel = {{5{state_reg.pin_irq_control[gpe_pkg::PIN_IRQ_CONTROL_EDGE0+2]}},
                   {8{state_reg.pin_irq_control[gpe_pkg::PIN_IRQ_CONTROL_EDGE0+1]}},
                   {8{state_reg.pin_irq_control[gpe_pkg::PIN_IRQ_CONTROL_EDGE0]}}};
  end

  // Port byte views of pins, events and pin-level enables
  always_comb
  begin
    pin_bytes    = bytes21(pin_level);
    hit_bytes    = bytes21(edge_hit);
    toggle_bytes = bytes21(toggle_hit);
    pin_en_bytes[0] = {{4{state_reg.pin_irq_control[gpe_pkg::PIN_IRQ_CONTROL_P0_HI]}},
                       {4{state_reg.pin_irq_control[gpe_pkg::PIN_IRQ_CONTROL_P0_LO]}}};
    pin_en_bytes[1] = state_reg.port_one_pin_enables;
    pin_en_bytes[2] = {8{state_reg.pin_irq_control[gpe_pkg::PIN_IRQ_CONTROL_P2_EN]}} &
                      gpe_pkg::PORT_TWO_MASK;
  end

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------

  // Port data reads the pins, never the latch
  always_comb
  begin
    rdata = 32'h0000_0000;
    for (int p = 0; p < gpe_pkg::NUM_PORTS; p++)
    begin
      if (paddr == port_off(gpe_pkg::OFF_DATA0, p))
        rdata[7:0] = pin_bytes[p];
      if (paddr == port_off(gpe_pkg::OFF_FSEL0, p))
        rdata[7:0] = state_reg.cfg[p].fsel;
      if (paddr == port_off(gpe_pkg::OFF_DIR0, p))
        rdata[7:0] = state_reg.cfg[p].dir;
      if (paddr == port_off(gpe_pkg::OFF_INP0, p))
        rdata[7:0] = state_reg.cfg[p].inp;
      if (paddr == port_off(gpe_pkg::OFF_FLAG0, p))
        rdata[7:0] = state_reg.flags[p];
    end
    if (paddr == gpe_pkg::OFF_P1EN)
      rdata[7:0] = state_reg.port_one_pin_enables;
    if (paddr == gpe_pkg::OFF_PIN_IRQ_CONTROL)
      rdata[gpe_pkg::PIN_IRQ_CONTROL_W-1:0] = state_reg.pin_irq_control;
    if (paddr == gpe_pkg::OFF_IENA)
      rdata[gpe_pkg::IENA_P0] = state_reg.port_zero_irq_enable;
    if (paddr == gpe_pkg::OFF_IENB)
    begin
      rdata[gpe_pkg::IENB_P1] = state_reg.port_one_irq_enable;
      rdata[gpe_pkg::IENB_P2] = state_reg.port_two_irq_enable;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  assign wr_done    = psel & penable & state_reg.pready & pwrite;
  assign deep_sleep = deep_sleep_mode_a | deep_sleep_mode_b;

  always_comb
  begin
    logic [1:0] mport;
    logic [7:0] clr;
    state_next = state_reg;
    mport      = pwdata[gpe_pkg::MOD_PORT_LSB +: 2];
    clr        = 8'h00;

    // No wait state: answer is prepared in the setup cycle
    state_next.pready  = 1'b0;
    state_next.pslverr = 1'b0;
    if (psel && !penable)
    begin
      state_next.pready  = 1'b1;
      state_next.pslverr = ~addr_mapped(paddr);
      state_next.prdata  = addr_mapped(paddr) ? rdata : 32'h0000_0000;
    end

    // Byte-wide configuration and latch writes
    for (int p = 0; p < gpe_pkg::NUM_PORTS; p++)
    begin
      if (wr_done && paddr == port_off(gpe_pkg::OFF_DATA0, p))
        state_next.latch[p] = pwdata[7:0] & port_mask(p);
      if (wr_done && paddr == port_off(gpe_pkg::OFF_FSEL0, p))
        state_next.cfg[p].fsel = pwdata[7:0] & port_mask(p);
      if (wr_done && paddr == port_off(gpe_pkg::OFF_DIR0, p))
        state_next.cfg[p].dir = pwdata[7:0] & port_mask(p);
      // Port two keeps its upper bits as pull-down selects
      if (wr_done && paddr == port_off(gpe_pkg::OFF_INP0, p))
        state_next.cfg[p].inp = pwdata[7:0];
    end

    // Bit and byte modify works on the latch, not the pins
    if (wr_done && paddr == gpe_pkg::OFF_MODIFY && mport != 2'h3)
      state_next.latch[mport] = modify_latch(state_reg.latch[mport],
                                             pwdata[gpe_pkg::MOD_OP_LSB +: 3],
                                             pwdata[gpe_pkg::MOD_BIT_LSB +: 3],
                                             pwdata[gpe_pkg::MOD_VAL_LSB +: 8])
                                & port_mask(int'(mport));

    if (wr_done && paddr == gpe_pkg::OFF_P1EN)
      state_next.port_one_pin_enables = pwdata[7:0];
    if (wr_done && paddr == gpe_pkg::OFF_PIN_IRQ_CONTROL)
      state_next.pin_irq_control = pwdata[gpe_pkg::PIN_IRQ_CONTROL_W-1:0];
    if (wr_done && paddr == gpe_pkg::OFF_IENA)
      state_next.port_zero_irq_enable = pwdata[gpe_pkg::IENA_P0];
    if (wr_done && paddr == gpe_pkg::OFF_IENB)
    begin
      state_next.port_one_irq_enable = pwdata[gpe_pkg::IENB_P1];
      state_next.port_two_irq_enable = pwdata[gpe_pkg::IENB_P2];
    end

    // Flags: a new edge beats a clear in the same cycle
    for (int p = 0; p < gpe_pkg::NUM_PORTS; p++)
    begin
      clr = (wr_done && paddr == port_off(gpe_pkg::OFF_FLAG0, p)) ? ~pwdata[7:0] : 8'h00;
      state_next.flags[p] = ((state_reg.flags[p] & ~clr) | hit_bytes[p]) & port_mask(p);
    end

    // Requests follow flags, pin enables and port enables
    state_next.irq[0] = state_reg.port_zero_irq_enable &
                        |(state_reg.flags[0] & pin_en_bytes[0]);
    state_next.irq[1] = state_reg.port_one_irq_enable &
                        |(state_reg.flags[1] & pin_en_bytes[1]);
    state_next.irq[2] = state_reg.port_two_irq_enable &
                        |(state_reg.flags[2] & pin_en_bytes[2]);

    // Trigger on any general-purpose input transition, either direction
    state_next.dma[0] = |toggle_bytes[0];
    state_next.dma[1] = |toggle_bytes[1];

    // Pad drive; frozen in either deep sleep mode, edges still watched
    if (!deep_sleep)
    begin
      state_next.pins.out = (fsel_flat & periph_out) | (~fsel_flat & latch_flat);
      state_next.pins.oe  = (fsel_flat & periph_oe) | (~fsel_flat & dir_flat);
      state_next.pins.pull_up   = ~state_next.pins.oe & ~inp_flat & ~pd_flat;
      state_next.pins.pull_down = ~state_next.pins.oe & ~inp_flat & pd_flat;
      state_next.pins.pull_up[gpe_pkg::HI_DRIVE_A]   = 1'b0;
      state_next.pins.pull_up[gpe_pkg::HI_DRIVE_B]   = 1'b0;
      state_next.pins.pull_down[gpe_pkg::HI_DRIVE_A] = 1'b0;
      state_next.pins.pull_down[gpe_pkg::HI_DRIVE_B] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Reset of all zero means GPIO, input, pull-up except on high-drive pins 8 and 9, no flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign prdata                = state_reg.prdata;
  assign pready                = state_reg.pready;
  assign pslverr               = state_reg.pslverr;
  assign pins                  = state_reg.pins;
  assign irq_port_zero         = state_reg.irq[0];
  assign irq_port_one          = state_reg.irq[1];
  assign irq_port_two          = state_reg.irq[2];
  assign port_zero_dma_trigger = state_reg.dma[0];
  assign port_one_dma_trigger  = state_reg.dma[1];

endmodule
`default_nettype wire

// *** dv/gpe_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
module gpe_checker (
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [31:0]                  prdata,
  input wire logic                         pready,
  input wire logic                         pslverr,
  input wire logic [gpe_pkg::NUM_PINS-1:0] pin_in,
  input wire logic                         deep_sleep_mode_a,
  input wire logic                         deep_sleep_mode_b,
  input wire gpe_pkg::gpe_pins_t           pins,
  input wire logic                         irq_port_zero,
  input wire logic                         irq_port_one,
  input wire logic                         irq_port_two,
  input wire logic                         port_zero_dma_trigger,
  input wire logic                         port_one_dma_trigger
);
  // ----------------------------------------------------------------
  // Port behaviour over time
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Either sleep input freezes the pads
  wire slp_any = deep_sleep_mode_a | deep_sleep_mode_b;
  sequence s_setup; psel && !penable; endsequence
  sequence s_refused; s_setup ##1 (pready && pslverr); endsequence
  property p_answer; s_setup |=> pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_refuse; s_refused |-> prdata == 32'h0; endproperty
  property p_pull; (pins.oe & (pins.pull_up | pins.pull_down)) == '0; endproperty
  property p_hdrive; pins.pull_up[9:8] == 2'h0 && pins.pull_down[9:8] == 2'h0; endproperty
  // Two cycles of slack so a write landing at entry is not misread
  property p_sleep; slp_any && $past(slp_any) && $past(slp_any, 2) |-> $stable(pins); endproperty
  property p_clear;
    ($fell(irq_port_zero) || $fell(irq_port_one) || $fell(irq_port_two))
      |-> $past(psel && penable && pwrite, 2);
  endproperty
  property p_dma0; port_zero_dma_trigger |-> $past(pin_in[7:0]) != $past(pin_in[7:0], 7); endproperty
  property p_dma1; port_one_dma_trigger |-> $past(pin_in[15:8]) != $past(pin_in[15:8], 7); endproperty
  a_answer: assert property (p_answer) else $error("no pready after setup");
  a_pulse: assert property (p_pulse) else $error("pready held two cycles");
  a_refuse: assert property (p_refuse) else $error("refused read with data");
  a_pull: assert property (p_pull) else $error("pull on a driven pin");
  a_hdrive: assert property (p_hdrive) else $error("pull on high-drive pin");
  a_sleep: assert property (p_sleep) else $error("pads moved in deep sleep");
  a_clear: assert property (p_clear) else $error("request dropped without write");
  a_dma0: assert property (p_dma0) else $error("port zero trigger without change");
  a_dma1: assert property (p_dma1) else $error("port one trigger without change");
endmodule
bind gpe_top gpe_checker i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready,
  .pslverr, .pin_in, .deep_sleep_mode_a, .deep_sleep_mode_b, .pins, .irq_port_zero,
  .irq_port_one, .irq_port_two, .port_zero_dma_trigger, .port_one_dma_trigger);
`default_nettype wire

// *** dv/gpe_pads.sv ***
`timescale 1ns/10ps
`default_nettype none
module gpe_pads (
  input wire logic               pclk,
  input wire gpe_pkg::gpe_pins_t pins,
  input wire logic [20:0]        ext_val,
  input wire logic [20:0]        ext_en,
  output logic     [20:0]        pin_in
);
  // ----------------------------------------------------------------
  // Wire resolution
  // ----------------------------------------------------------------
  logic [20:0] flt_reg = 21'h0;
  // Floating pads wander, so no stale level reads as valid
  always @(posedge pclk) flt_reg <= ~flt_reg;
  // Device first, then outside driver, then pull, else floating
  assign pin_in = (pins.oe & pins.out) | (~pins.oe & ext_en & ext_val)
    | (~pins.oe & ~ext_en & (pins.pull_up | (~pins.pull_down & flt_reg)));
endmodule
`default_nettype wire

// *** dv/test_gpio_ports_edge_interrupts.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_gpio_ports_edge_interrupts;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0]         paddr, e;
  logic [31:0]        pwdata, prdata, rdat;
  logic [20:0]        pin_in, ext_val, ext_en, p_out, p_oe;
  logic [1:0]         slp, seen;
  logic               irq_port_zero, irq_port_one, irq_port_two;
  logic               port_zero_dma_trigger, port_one_dma_trigger;
  gpe_pkg::gpe_pins_t pins;
  int                 n_mismatch, n_checks, cyc;
  wire                deep_sleep_mode_a = slp[0];
  wire                deep_sleep_mode_b = slp[1];
  gpe_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pin_in, .periph_out(p_out), .periph_oe(p_oe), .deep_sleep_mode_a,
    .deep_sleep_mode_b, .pins, .irq_port_zero, .irq_port_one, .irq_port_two,
    .port_zero_dma_trigger, .port_one_dma_trigger);
  gpe_pads i_pads (.pclk, .pins, .ext_val, .ext_en, .pin_in);
  // Clock and hang guard
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_mismatch++;
      conclude;
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  // Holds the request until pready is seen high at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
  task rd(input logic [7:0] a, input logic [31:0] x); apb(1'b0, a, 32'h0); chk(rdat, x); endtask
  // One flag per write, so no spurious request is provoked
  task clr(input logic [7:0] a);
    for (int i = 0; i < 8; i++) wr(a, 32'hFF ^ (32'h1 << i));
  endtask
  // Lets pin changes cross the synchroniser, noting trigger pulses
  task settle;
    seen = 2'b00;
    repeat (6)
    begin
      @(posedge pclk);
      seen = seen | {port_one_dma_trigger, port_zero_dma_trigger};
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    rd(8'h0C, 32'h0);
    rd(8'h18, 32'h0);
    chk(pins.pull_up, 32'h1FFCFF);
    chk(pins.oe, 32'h0);
    wr(8'h24, 32'h0F);
    wr(8'h2C, 32'h20);
    rd(8'h2C, 32'h20);
    chk(pins.pull_down, 32'hF0);
    chk(pins.pull_up, 32'h1FFC00);
    wr(8'h24, 32'h0);
    wr(8'h2C, 32'h0);
    wr(8'h14, 32'hFF);
    rd(8'h14, 32'h1F);
    wr(8'h14, 32'h0);
    apb(1'b0, 8'h50, 32'h0);
    chk(rerr, 32'h1);
  endtask
  task t_latch;
    ext_val <= 21'h003C00;
    wr(8'h04, 32'h5A);
    settle;
    chk(seen[1], 32'h1);
    rd(8'h04, 32'h3C);
    wr(8'h4C, 32'h00810011);
    wr(8'h4C, 32'h00000241);
    wr(8'h4C, 32'h00210021);
    wr(8'h4C, 32'h00000131);
    wr(8'h4C, 32'h00F70001);
    wr(8'h4C, 32'h00000051);
    wr(8'h1C, 32'hFF);
    ext_en <= 21'h1F00FF;
    settle;
    chk(pins.out[15:8], 32'hF5);
    chk(pins.oe[15:8], 32'hFF);
    rd(8'h04, 32'hF5);
    ext_en <= 21'h1FFFFF;
    wr(8'h1C, 32'h0);
    ext_val <= 21'h0;
    settle;
    clr(8'h34);
  endtask
  task t_irq;
    wr(8'h3C, 32'h08);
    wr(8'h48, 32'h02);
    ext_val <= 21'h001800;
    settle;
    chk(seen[1], 32'h1);
    rd(8'h34, 32'h18);
    chk(irq_port_one, 32'h1);
    wr(8'h34, 32'hF7);
    rd(8'h34, 32'h10);
    chk(irq_port_one, 32'h0);
    wr(8'h40, 32'h02);
    ext_val <= 21'h0;
    settle;
    rd(8'h34, 32'h18);
    chk(irq_port_one, 32'h1);
    wr(8'h40, 32'h28);
    wr(8'h44, 32'h01);
    wr(8'h48, 32'h04);
    ext_val <= 21'h100020;
    settle;
    chk(seen[0], 32'h1);
    chk(irq_port_zero, 32'h0);
    chk(irq_port_one, 32'h0);
    chk(irq_port_two, 32'h1);
    rd(8'h38, 32'h10);
    wr(8'h0C, 32'h40);
    {p_out, p_oe} <= {21'h000040, 21'h000040};
    ext_val <= 21'h100062;
    settle;
    rd(8'h30, 32'h22);
    chk(irq_port_zero, 32'h1);
    chk(pins.out[6], 32'h1);
    chk(pins.oe[6], 32'h1);
  endtask
  task t_sleep;
    wr(8'h0C, 32'h0);
    wr(8'h18, 32'hFF);
    ext_en <= 21'h1FFF00;
    wr(8'h00, 32'h11);
    e = 8'h11;
    for (int k = 0; k < 2; k++)
    begin
      // Latch reaches the pads one edge after its write
      @(posedge pclk);
      slp <= 2'b01 << k;
      wr(8'h00, {24'h0, ~e});
      ext_val[17 + k] <= 1'b1;
      settle;
      chk(pins.out[7:0], e);
      rd(8'h38, k ? 32'h16 : 32'h12);
      slp <= 2'b00;
      repeat (2) @(posedge pclk);
      e = ~e;
      chk(pins.out[7:0], e);
    end
  endtask
  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {ext_val, p_out, p_oe, slp, n_mismatch, n_checks, cyc} = '0;
    ext_en = 21'h1FFFFF;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    t_reset;
    t_latch;
    t_irq;
    t_sleep;
    conclude;
  end
endmodule
`default_nettype wire
